// ---- inc/pss_pkg.sv ----
// pss_pkg: constants, register map and types of the program segment sequencer
// assumes a 20 MHz reference clock and 32-bit apb data
package pss_pkg;
    // program table geometry
    localparam int SEG_W = 3;
    localparam int PROG_W = 2;
    localparam int N_SEG = 1 << SEG_W;
    localparam int N_PROG = 1 << PROG_W;
    localparam int IDX_W = SEG_W + PROG_W;
    localparam int RPT_W = 14;
    localparam int VAL_W = 16;
    localparam int SP_W = VAL_W + 1;
    localparam int CNT_W = SEG_W + 1;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIME_UNIT_NS = 1000000000;
    localparam int TIME_UNIT_CYC = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_NS = 500000000;
    localparam int BLINK_CYC = BLINK_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CFG = 12'h004;
    localparam logic [11:0] OFF_REPEAT = 12'h008;
    localparam logic [11:0] OFF_LINK = 12'h00c;
    localparam logic [11:0] OFF_STEP = 12'h010;
    localparam logic [11:0] OFF_BAND = 12'h014;
    localparam logic [11:0] OFF_SHIFT = 12'h018;
    localparam logic [11:0] OFF_STATUS = 12'h01c;
    localparam logic [11:0] OFF_ELAPSED = 12'h020;
    localparam logic [11:0] OFF_TABLE = 12'h100;
    localparam logic [11:0] TABLE_MASK = 12'hf80;

    // control bit positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_PAUSE = 2;
    localparam int CTRL_ADV = 3;
    localparam int CTRL_DISP1 = 4;
    // config, link, table entry and status field positions
    localparam int CFG_END_LSB = 0;
    localparam int CFG_CNT_LSB = 4;
    localparam int CFG_START_LSB = 8;
    localparam int LINK_END_BIT = 8;
    localparam int TBL_SP_LSB = 16;
    localparam int ST_REP_LSB = 16;

    // reset values
    localparam logic [CNT_W-1:0] SEG_CNT_RST = 4'h8;
    localparam logic [RPT_W-1:0] RPT_RST = 14'h0000;
    localparam logic [VAL_W-1:0] BAND_OFF = 16'h0000;
    localparam logic [VAL_W-1:0] SHIFT_RST = 16'h0000;

    // end-of-operation behaviour
    typedef enum logic [1:0] {
        END_RESET = 2'h0,
        END_CONTINUE = 2'h1,
        END_FIXED = 2'h2
    } pss_endop_e;

    // sequencer state
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_DONE = 3'h4
    } pss_state_e;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pss_apb_req_s;

    // sequencer status toward the user side
    typedef struct packed {
        logic running;
        logic paused;
        logic waiting;
        logic done;
        logic [PROG_W-1:0] prog;
        logic [SEG_W-1:0] step_index_setting;
    } pss_status_s;
endpackage

// ---- core/pss_sequencer.sv ----
// pss_sequencer: steps a setpoint program through timed segments, apb register slave
// assumes synchronous event inputs and an apb master on ref_clk_i
//
// Operation
// - advance ends segment, next segment starts
// - advance flag self-clears after the step
// - advance ignored in reset/standby/autotune/continue
// - step index write jumps to segment start
// - jump refused in reset/standby/autotune/continue
// - pause freezes segment timing, resumes later
// - pause cleared by off, run/reset, completion
// - advance while paused stays paused next segment
// - pause ignored in reset/standby/autotune/continue
// - segment end waits for deviation inside band
// - band zero means off, no waiting
// - leave wait same cycle deviation enters band
// - wait disable event suppresses waiting
// - nonzero repeat restarts program at segment 0
// - executions equal repeat count plus one
// - lowered repeat count stops after current run
// - link continues at chosen program, end stops
// - link only after all repetitions
// - link to itself repeats forever
// - chain end follows end-of-operation setting
// - output setpoint adds global offset
// - paused display alternates while pv shown
`timescale 1ns/10ps
module pss_sequencer import pss_pkg::*; #(
    parameter int TIME_UNIT = TIME_UNIT_CYC,
    parameter int BLINK = BLINK_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire pss_apb_req_s apb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // process and event inputs
    input wire logic signed [VAL_W-1:0] pv_i,
    input wire logic forward_step_event_i,
    input wire logic pause_toggle_event_i,
    input wire logic pause_level_event_i,
    input wire logic wait_disable_i,
    input wire logic standby_i,
    input wire logic autotune_i,
    // sequencer outputs
    output pss_status_s status_o,
    output logic signed [SP_W-1:0] setpoint_o,
    output logic disp2_alt_o
);
    // table decode, used for read and write
    function automatic logic is_table(input logic [11:0] a);
        is_table = (a & TABLE_MASK) == OFF_TABLE;
    endfunction

    // register and state storage
    pss_state_e state_q;
    logic [SEG_W-1:0] seg_q;
    logic [PROG_W-1:0] prog_q;
    logic [31:0] elapsed_q;
    logic [RPT_W-1:0] rep_q;
    logic [RPT_W-1:0] repeat_count_q;
    logic [PROG_W-1:0] next_program_select_q;
    logic link_end_q;
    logic [1:0] end_op_q;
    logic [CNT_W-1:0] seg_cnt_q;
    logic [PROG_W-1:0] start_prog_q;
    logic [VAL_W-1:0] band_q;
    logic [VAL_W-1:0] setpoint_offset_q;
    logic pause_control_q;
    logic adv_req_q;
    logic disp1_q;
    logic toggle_prev_q;
    logic [31:0] tbl_q [N_PROG*N_SEG];
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [31:0] blink_cnt_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    pss_status_s status_q;
    logic signed [SP_W-1:0] setpoint_q;
    logic disp_q;

    // bus strobes
    logic acc;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    assign addr = apb_i.paddr;
    assign wdata = apb_i.pwdata;
    assign acc = apb_i.psel & apb_i.penable & ~pready_q;
    assign wr = apb_i.psel & apb_i.penable & pready_q & apb_i.pwrite;

    // command decode
    logic wr_ctrl;
    logic run_cmd;
    logic rst_cmd;
    logic running;
    logic blocked;
    assign wr_ctrl = wr & (addr == OFF_CTRL);
    assign run_cmd = wr_ctrl & wdata[CTRL_RUN];
    assign rst_cmd = wr_ctrl & wdata[CTRL_RESET];
    assign running = state_q == ST_RUN;
    assign blocked = ~running | standby_i | autotune_i
        | (end_op_q == 2'(END_CONTINUE));

    // present segment data and deviation
    logic [IDX_W-1:0] idx;
    logic [VAL_W-1:0] seg_time;
    logic signed [VAL_W-1:0] present_setpoint;
    logic signed [SP_W-1:0] dev;
    logic [SP_W-1:0] dev_abs;
    logic in_band;
    logic wait_on;
    assign idx = {prog_q, seg_q};
    assign seg_time = tbl_q[idx][VAL_W-1:0];
    assign present_setpoint = tbl_q[idx][TBL_SP_LSB +: VAL_W];
    assign dev = SP_W'(pv_i) - SP_W'(present_setpoint);
    assign dev_abs = dev[SP_W-1] ? SP_W'(-dev) : SP_W'(dev);
    assign in_band = dev_abs <= {1'b0, band_q};
    assign wait_on = (band_q != BAND_OFF) & ~wait_disable_i;

    // segment sequencing conditions
    logic paused;
    logic frozen;
    logic seg_end;
    logic hold_wait;
    logic nat_end;
    logic adv_go;
    logic do_step;
    logic last_seg;
    logic jump_go;
    logic prog_end;
    logic more_rep;
    logic finish;
    assign paused = ~blocked & (pause_control_q | pause_level_event_i);
    assign frozen = paused | standby_i | autotune_i;
    assign seg_end = running & ~frozen & (elapsed_q >= 32'(seg_time));
    assign hold_wait = seg_end & wait_on & ~in_band;
    assign nat_end = seg_end & ~hold_wait;
    assign adv_go = adv_req_q & ~blocked;
    assign do_step = nat_end | adv_go;
    assign last_seg = CNT_W'(seg_q) + 4'h1 >= seg_cnt_q;
    assign jump_go = wr & (addr == OFF_STEP) & ~blocked
        & (wdata[CNT_W-1:0] < seg_cnt_q);
    assign prog_end = do_step & ~jump_go & last_seg;
    assign more_rep = rep_q < repeat_count_q;
    assign finish = prog_end & more_rep == 1'b0 & link_end_q;

    // time unit divider
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= 32'(TIME_UNIT - 1)) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

    // sequencer state, segment, program, repetition and elapsed time
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            seg_q <= '0;
            prog_q <= '0;
            elapsed_q <= 32'h0;
            rep_q <= '0;
        end else if (rst_cmd) begin
            state_q <= ST_IDLE;
            seg_q <= '0;
            elapsed_q <= 32'h0;
            rep_q <= '0;
        end else if (run_cmd) begin
            state_q <= ST_RUN;
            seg_q <= '0;
            prog_q <= start_prog_q;
            elapsed_q <= 32'h0;
            rep_q <= '0;
        end else if (jump_go) begin
            seg_q <= wdata[SEG_W-1:0];
            elapsed_q <= 32'h0;
        end else if (prog_end) begin
            elapsed_q <= 32'h0;
            if (more_rep) begin
                rep_q <= rep_q + 14'h1;
                seg_q <= '0;
            end else if (!link_end_q) begin
                prog_q <= next_program_select_q;
                rep_q <= '0;
                seg_q <= '0;
            end else if (end_op_q == 2'(END_RESET)) begin
                state_q <= ST_IDLE;
            end else begin
                state_q <= ST_DONE;
            end
        end else if (do_step) begin
            seg_q <= seg_q + 3'h1;
            elapsed_q <= 32'h0;
        end else if (running && !frozen && !seg_end && tick_q) begin
            elapsed_q <= elapsed_q + 32'h1;
        end
    end

    // advance request flag, set wins over the self clear
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            adv_req_q <= 1'b0;
        end else if (!blocked && (forward_step_event_i || (wr_ctrl && wdata[CTRL_ADV]))) begin
            adv_req_q <= 1'b1;
        end else if (adv_go || blocked) begin
            adv_req_q <= 1'b0;
        end
    end

    // pause control
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pause_control_q <= 1'b0;
            toggle_prev_q <= 1'b0;
        end else begin
            toggle_prev_q <= pause_toggle_event_i;
            if (run_cmd || rst_cmd || finish) begin
                pause_control_q <= 1'b0;
            end else if (wr_ctrl) begin
                pause_control_q <= wdata[CTRL_PAUSE] & ~blocked;
            end else if (pause_toggle_event_i && !toggle_prev_q && !blocked) begin
                pause_control_q <= ~pause_control_q;
            end else if (blocked) begin
                pause_control_q <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp1_q <= 1'b0;
            end_op_q <= 2'(END_RESET);
            seg_cnt_q <= SEG_CNT_RST;
            start_prog_q <= '0;
            repeat_count_q <= RPT_RST;
            next_program_select_q <= '0;
            link_end_q <= 1'b1;
            band_q <= BAND_OFF;
            setpoint_offset_q <= SHIFT_RST;
        end else if (wr) begin
            unique case (addr)
                OFF_CTRL: disp1_q <= wdata[CTRL_DISP1];
                OFF_CFG: begin
                    end_op_q <= wdata[CFG_END_LSB +: 2];
                    seg_cnt_q <= wdata[CFG_CNT_LSB +: CNT_W];
                    start_prog_q <= wdata[CFG_START_LSB +: PROG_W];
                end
                OFF_REPEAT: repeat_count_q <= wdata[RPT_W-1:0];
                OFF_LINK: begin
                    next_program_select_q <= wdata[PROG_W-1:0];
                    link_end_q <= wdata[LINK_END_BIT];
                end
                OFF_BAND: band_q <= wdata[VAL_W-1:0];
                OFF_SHIFT: setpoint_offset_q <= wdata[VAL_W-1:0];
                default: ;
            endcase
        end
    end

    // program table storage
    generate
        for (genvar i = 0; i < N_PROG*N_SEG; i++) begin : g_tbl
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    tbl_q[i] <= 32'h0;
                end else if (wr && is_table(addr) && addr[IDX_W+1:2] == IDX_W'(i)) begin
                    tbl_q[i] <= wdata;
                end
            end
        end
    endgenerate

    // apb answer, one wait state
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
            if (acc) begin
                if (is_table(addr)) begin
                    prdata_q <= tbl_q[addr[IDX_W+1:2]];
                end else begin
                    unique case (addr)
                        OFF_CTRL: prdata_q <= 32'({disp1_q, adv_req_q, pause_control_q, 2'h0});
                        OFF_CFG: prdata_q <= 32'({start_prog_q, seg_cnt_q, 2'h0, end_op_q});
                        OFF_REPEAT: prdata_q <= 32'(repeat_count_q);
                        OFF_LINK: prdata_q <= 32'({link_end_q, 6'h0, next_program_select_q});
                        OFF_STEP: prdata_q <= 32'(seg_q);
                        OFF_BAND: prdata_q <= 32'(band_q);
                        OFF_SHIFT: prdata_q <= 32'(setpoint_offset_q);
                        OFF_STATUS: prdata_q <= {2'h0, rep_q, 7'h0, status_q};
                        OFF_ELAPSED: prdata_q <= elapsed_q;
                        default: pslverr_q <= 1'b1;
                    endcase
                end
            end
        end
    end

    // status and shifted setpoint
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_q <= '0;
            setpoint_q <= '0;
        end else begin
            status_q.running <= running;
            status_q.paused <= paused;
            status_q.waiting <= hold_wait;
            status_q.done <= state_q == ST_DONE;
            status_q.prog <= prog_q;
            status_q.step_index_setting <= seg_q;
            setpoint_q <= SP_W'(present_setpoint) + SP_W'($signed(setpoint_offset_q));
        end
    end

    // second display alternation while paused
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blink_cnt_q <= 32'h0;
            disp_q <= 1'b0;
        end else if (!(paused && disp1_q)) begin
            blink_cnt_q <= 32'h0;
            disp_q <= 1'b0;
        end else if (blink_cnt_q >= 32'(BLINK - 1)) begin
            blink_cnt_q <= 32'h0;
            disp_q <= ~disp_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // outputs straight from flops
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign status_o = status_q;
    assign setpoint_o = setpoint_q;
    assign disp2_alt_o = disp_q;
endmodule

// ---- dv/pss_sequencer_sva.sv ----
// pss_sequencer_sva: port-level assertions for the program segment sequencer
// assumes binding onto pss_sequencer, one clock domain, reset active low
`timescale 1ns/10ps
module pss_sequencer_sva import pss_pkg::*; (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // apb
    input wire pss_apb_req_s apb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // process and events
    input wire logic signed [VAL_W-1:0] pv_i,
    input wire logic forward_step_event_i,
    input wire logic pause_toggle_event_i,
    input wire logic pause_level_event_i,
    input wire logic wait_disable_i,
    input wire logic standby_i,
    input wire logic autotune_i,
    // sequencer outputs
    input wire pss_status_s status_o,
    input wire logic signed [SP_W-1:0] setpoint_o,
    input wire logic disp2_alt_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // access phase still waiting for its answer
    sequence s_access;
        apb_i.psel && apb_i.penable && !pready_o;
    endsequence
    // paused with no advance and no bus traffic
    sequence s_quiet_pause;
        status_o.paused && !forward_step_event_i && !apb_i.psel;
    endsequence
    // blocked by standby or autotune, no bus traffic
    sequence s_blocked;
        (standby_i || autotune_i) && !apb_i.psel;
    endsequence

    a_apb_one_wait: assert property (s_access |=> pready_o)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    a_err_no_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("slave error without ready or with data");
    a_block_unpause: assert property (s_blocked [*3] |-> !status_o.paused)
        else $error("paused while blocked");
    a_block_keeps_seg: assert property (s_blocked [*3] |-> $stable(status_o.step_index_setting))
        else $error("segment moved while blocked");
    a_wait_suppressed: assert property (wait_disable_i [*3] |-> !status_o.waiting)
        else $error("waiting while wait disabled");
    a_alt_only_paused: assert property (disp2_alt_o |-> status_o.paused || $past(status_o.paused))
        else $error("alternate display without pause");
    a_adv_keeps_pause: assert property ($changed(status_o.step_index_setting) && $past(status_o.paused) &&
        status_o.running && status_o.step_index_setting != 0 && !$past(apb_i.psel, 2) |-> status_o.paused)
        else $error("pause lost on advance");
    a_pause_freezes: assert property (s_quiet_pause [*4] |-> $stable(status_o.step_index_setting))
        else $error("segment moved while paused");
endmodule

bind pss_sequencer pss_sequencer_sva u_sva (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .apb_i(apb_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pv_i(pv_i),
    .forward_step_event_i(forward_step_event_i), .pause_toggle_event_i(pause_toggle_event_i),
    .pause_level_event_i(pause_level_event_i), .wait_disable_i(wait_disable_i),
    .standby_i(standby_i), .autotune_i(autotune_i), .status_o(status_o),
    .setpoint_o(setpoint_o), .disp2_alt_o(disp2_alt_o)
);

// ---- dv/pss_sequencer_test.sv ----
// pss_sequencer_test: directed self-checking bench for the sequencer
// assumes pss_pkg, the sequencer and its checker are compiled first
`timescale 1ns/10ps
module pss_sequencer_test import pss_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    pss_apb_req_s apb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, alt;
    logic fwd = 1'b0, tog = 1'b0, lvl = 1'b0, wdis = 1'b0, stby = 1'b0, atune = 1'b0;
    logic signed [VAL_W-1:0] pv = '0;
    logic signed [SP_W-1:0] sp;
    pss_status_s st;
    logic [31:0] rdat, e1;
    logic rerr;
    int n_errors = 0;
    int num_checks = 0;
    int execs [N_PROG];

    // 20 MHz clock
    always #25 ref_clk_i = ~ref_clk_i;

    pss_sequencer #(.TIME_UNIT(4), .BLINK(3)) u_dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .apb_i(apb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pv_i(pv), .forward_step_event_i(fwd),
        .pause_toggle_event_i(tog), .pause_level_event_i(lvl), .wait_disable_i(wdis),
        .standby_i(stby), .autotune_i(atune), .status_o(st), .setpoint_o(sp),
        .disp2_alt_o(alt)
    );

    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk_i);
        apb.penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        rdat = prdata;
        rerr = pslverr;
        apb <= '0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic wait_seg(input int s, input int lim);
        int n;
        n = 0;
        while (st.step_index_setting !== SEG_W'(s) && n < lim) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk("seg", 32'(s), 32'(st.step_index_setting));
    endtask
    // program table: time t units, setpoint 100 + 10 per word
    task automatic fill(input int t);
        for (int i = 0; i < 16; i++) wr(OFF_TABLE + 12'(4 * i), {16'(100 + 10 * i), 16'(t)});
    endtask
    // counts executions started in each program
    task automatic trace(input int n);
        logic prun;
        logic [SEG_W-1:0] pseg;
        prun = 1'b0;
        pseg = '0;
        execs = '{default: 0};
        repeat (n) begin
            @(posedge ref_clk_i);
            if (st.running && st.step_index_setting == 0 && (!prun || pseg != 0)) execs[st.prog]++;
            prun = st.running;
            pseg = st.step_index_setting;
        end
    endtask

    task automatic s_regs();
        xfer(1'b0, OFF_CFG, 32'h0);
        chk("cfg", 32'h80, rdat);
        wr(OFF_CFG, 32'h380);
        xfer(1'b0, OFF_CFG, 32'h0);
        chk("cfg_rw", 32'h380, rdat);
        wr(OFF_CFG, 32'h80);
        xfer(1'b0, OFF_LINK, 32'h0);
        chk("link", 32'h100, rdat);
        xfer(1'b0, 12'h0f0, 32'h0);
        chk("slverr", 32'h1, 32'(rerr));
    endtask
    task automatic s_shift();
        wr(OFF_SHIFT, 32'h0000fff6);
        fill(50);
        wr(OFF_CTRL, 32'h1);
        cyc(4);
        chk("setpoint", 32'(90), 32'(sp));
    endtask
    task automatic s_adv();
        wr(OFF_CTRL, 32'h8);
        wait_seg(1, 10);
        xfer(1'b0, OFF_CTRL, 32'h0);
        chk("adv_flag", 32'h0, 32'(rdat[CTRL_ADV]));
        fwd <= 1'b1;
        cyc(1);
        fwd <= 1'b0;
        wait_seg(2, 10);
        // standby, autotune, then end-of-operation set to continue
        for (int k = 0; k < 3; k++) begin
            stby <= (k == 0);
            atune <= (k == 1);
            if (k == 2) wr(OFF_CFG, 32'h81);
            cyc(3);
            wr(OFF_CTRL, 32'hc);
            wr(OFF_STEP, 32'h5);
            cyc(4);
            chk("blocked", 32'h2, 32'({st.paused, st.step_index_setting}));
            stby <= 1'b0;
            atune <= 1'b0;
            if (k == 2) wr(OFF_CFG, 32'h80);
            cyc(6);
            chk("unblocked", 32'h2, 32'({st.paused, st.step_index_setting}));
        end
    endtask
    task automatic s_jump();
        wr(OFF_STEP, 32'h7);
        wait_seg(7, 6);
        wr(OFF_STEP, 32'h8);
        cyc(4);
        chk("over_range", 32'h7, 32'(st.step_index_setting));
        wr(OFF_STEP, 32'h0);
        wait_seg(0, 6);
    endtask
    task automatic s_pause();
        int n;
        wr(OFF_CTRL, 32'h14);
        cyc(3);
        xfer(1'b0, OFF_ELAPSED, 32'h0);
        e1 = rdat;
        cyc(20);
        xfer(1'b0, OFF_ELAPSED, 32'h0);
        chk("elapsed", e1, rdat);
        n = 0;
        for (int i = 0; i < 12; i++) begin
            e1[0] = alt;
            @(posedge ref_clk_i);
            if (alt !== e1[0]) n++;
        end
        chk("blink", 32'h4, 32'(n));
        wr(OFF_CTRL, 32'h1c);
        wait_seg(1, 10);
        chk("paused", 32'h1, 32'(st.paused));
        fwd <= 1'b1;
        cyc(1);
        fwd <= 1'b0;
        wait_seg(2, 10);
        chk("paused_fwd", 32'h1, 32'(st.paused));
        wr(OFF_CTRL, 32'h10);
        cyc(3);
        chk("unpaused", 32'h0, 32'({st.paused, alt}));
        tog <= 1'b1;
        cyc(1);
        tog <= 1'b0;
        cyc(3);
        chk("toggle", 32'h1, 32'(st.paused));
        wr(OFF_CTRL, 32'h1);
        cyc(3);
        chk("run_clears", 32'h0, 32'(st.paused));
        lvl <= 1'b1;
        cyc(3);
        chk("level", 32'h1, 32'(st.paused));
        lvl <= 1'b0;
        cyc(3);
        chk("level_off", 32'h0, 32'(st.paused));
    endtask
    task automatic s_wait();
        wr(OFF_SHIFT, 32'h0);
        wr(OFF_BAND, 32'h5);
        fill(2);
        wr(OFF_STEP, 32'h0);
        cyc(30);
        chk("waiting", 32'h1, 32'({st.step_index_setting, st.waiting}));
        pv <= 16'sd98;
        wait_seg(1, 4);
        cyc(20);
        chk("waiting2", 32'h3, 32'({st.step_index_setting, st.waiting}));
        wdis <= 1'b1;
        wait_seg(2, 4);
        wdis <= 1'b0;
        pv <= '0;
        wr(OFF_BAND, 32'h0);
        wait_seg(3, 20);
    endtask
    task automatic run_case(input logic [31:0] cfg, input logic [31:0] rpt,
        input logic [31:0] link, input logic [31:0] late);
        wr(OFF_CTRL, 32'h2);
        wr(OFF_CFG, cfg);
        wr(OFF_REPEAT, rpt);
        wr(OFF_LINK, link);
        fork
            trace(200);
            begin
                wr(OFF_CTRL, 32'h1);
                if (late != rpt) wr(OFF_REPEAT, late);
            end
        join
    endtask
    task automatic s_repeat();
        run_case(32'h20, 32'h1, 32'h100, 32'h1);
        chk("execs", 32'h2, 32'(execs[0]));
        chk("end_reset", 32'h0, 32'({st.running, st.done}));
        run_case(32'h20, 32'h1, 32'h1, 32'h1);
        chk("execs_link", 32'h2, 32'(execs[0]));
        chk("prog_run", 32'h3, 32'({st.prog, st.running}));
        chk("self_link", 32'h1, 32'(execs[1] >= 3));
        run_case(32'h22, 32'h3, 32'h100, 32'h0);
        chk("execs_cut", 32'h1, 32'(execs[0]));
        chk("end_fixed", 32'h1, 32'({st.running, st.done}));
    endtask

    // watchdog
    initial begin
        cyc(20000);
        n_errors++;
        conclude();
    end
    // main sequence
    initial begin
        cyc(16);
        rstn_i <= 1'b1;
        s_regs();
        s_shift();
        s_adv();
        s_jump();
        s_pause();
        s_wait();
        s_repeat();
        conclude();
    end
endmodule
